// File: bench/eag_mem_model.sv
/*
  Program and data memory model for the effective-address sequencer's read port.
  Assumes the bench loads every byte it expects to be read through put().
*/
`timescale 1ns/100ps
`default_nettype none
module eag_mem_model (
  input wire logic ref_clk,
  input wire logic rd_req,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  logic [7:0] mem [logic [15:0]];
  int wait_n;
  logic took;

  // Loads one byte; the bench calls this only between instructions.
  function automatic void put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endfunction : put

  // Idle values at time zero.
  initial begin
    rd_valid = 1'b0;
    rd_data = 8'h5a;
    wait_n = 0;
  end

  // Answers just after an edge, after zero to two wait cycles. Outside a valid answer
  // the data lines toggle every cycle, so a design that samples stale data is caught.
  always @(posedge ref_clk) begin
    took = rd_req && rd_valid;
    #1;
    if (took) begin
      rd_valid = 1'b0;
      rd_data = ~rd_data;
      wait_n = $urandom_range(0, 2);
    end else if (rd_req && !rd_valid && wait_n == 0) begin
      rd_valid = 1'b1;
      rd_data = mem.exists(rd_addr) ? mem[rd_addr] : 8'h00;
    end else if (!rd_valid) begin
      if (rd_req) wait_n--;
      rd_data = ~rd_data;
    end
  end
endmodule : eag_mem_model
`default_nettype wire

// File: bench/eag_top_bench.sv
/*
  Self-checking bench for the effective-address sequencer: a driver that offers
  opcodes and queues predictions, a monitor that pops them on each result.
  Assumes the memory model answers the read port and clk_en may stall anywhere.
*/
`timescale 1ns/100ps
`default_nettype none
module eag_top_bench;
  import eag_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] npc;
    eag_mode_t mode;
    logic cw;
    logic cv;
    logic ca;
    logic [7:0] opc;
  } eag_exp_t;
  logic ref_clk, rst_b, clk_en, instr_valid, branch_cond, instr_ready, rd_req, rd_valid;
  logic [7:0] instr_opcode, index_val, rd_data;
  logic [15:0] instr_pc, rd_addr, addr_bus, next_pc;
  logic addr_valid, bit_sense_out, uses_index_out, carry_we, carry_val, stall_on, held;
  logic [2:0] bit_num_out;
  eag_mode_t mode_out;
  eag_exp_t exp_q[$];
  eag_exp_t e;
  int fails, checks_done, seed_v;

  eag_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_pc(instr_pc), .index_val(index_val),
    .branch_cond(branch_cond), .instr_ready(instr_ready), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .addr_bus(addr_bus), .addr_valid(addr_valid),
    .next_pc(next_pc), .mode_out(mode_out), .bit_num_out(bit_num_out),
    .bit_sense_out(bit_sense_out), .uses_index_out(uses_index_out), .carry_we(carry_we),
    .carry_val(carry_val));
  eag_mem_model mem (.ref_clk(ref_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid));

  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Reference result of one instruction, reckoned from the addressing rules.
  function automatic eag_exp_t predict(input logic [7:0] op, input logic [15:0] pc,
      input logic [7:0] x, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] tb,
      input logic c);
    eag_exp_t r;
    logic [15:0] br;
    logic bv;
    r = '0;
    r.opc = op;
    r.ca = 1'b1;
    br = pc + 16'h0002 + {{8{b1[7]}}, b1};
    bv = tb[op[3:1]];
    case (op[7:4])
      4'h0: begin
        r.mode = M_BIT_BRANCH;
        r.addr = {8'h00, b1};
        r.cw = 1'b1;
        r.cv = bv;
        r.npc = (bv ^ op[0]) ? pc + 16'h0003 + {{8{b2[7]}}, b2} : pc + 16'h0003;
      end
      4'h1: begin
        r.mode = M_BIT_MODIFY;
        r.addr = {8'h00, b1};
        r.npc = pc + 16'h0002;
      end
      4'h3, 4'hb: begin
        r.mode = M_PAGE_ZERO;
        r.addr = {8'h00, b1};
        r.npc = pc + 16'h0002;
      end
      4'h4, 4'h5, 4'h8, 4'h9: begin
        r.mode = M_IMPLIED;
        r.npc = pc + 16'h0001;
      end
      4'h6, 4'he: begin
        r.mode = M_IDX_BYTE;
        r.addr = 16'(x) + 16'(b1);
        r.npc = pc + 16'h0002;
      end
      4'h7, 4'hf: begin
        r.mode = M_IDX_NONE;
        r.addr = {8'h00, x};
        r.npc = pc + 16'h0001;
      end
      4'hc: begin
        r.mode = M_FULL_ADDR;
        r.addr = {b1, b2};
        r.npc = pc + 16'h0003;
      end
      4'hd: begin
        r.mode = M_IDX_WORD;
        r.addr = {b1, b2} + 16'(x);
        r.npc = pc + 16'h0003;
      end
      default: begin
        r.mode = (op == OPC_SUB_CALL || op[7:4] == 4'h2) ? M_BRANCH : M_LITERAL;
        r.addr = (r.mode == M_BRANCH) ? br : pc + 16'h0001;
        r.npc = (r.mode == M_BRANCH && !c) ? pc + 16'h0002 : (r.mode == M_BRANCH) ? br : pc + 16'h0002;
      end
    endcase
    return r;
  endfunction : predict

  // Offers one opcode at a falling edge, holds it until taken, queues the prediction.
  task automatic send(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] x,
      input logic [7:0] b1, input logic [7:0] b2, input logic c);
    logic [7:0] tb;
    logic ok;
    int n;
    tb = 8'($urandom);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 200);
    mem.put(pc + 16'h0001, b1);
    mem.put(pc + 16'h0002, b2);
    if (op[7:4] == 4'h0) mem.put({8'h00, b1}, tb);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_pc = pc;
    index_val = x;
    branch_cond = c;
    n = 0;
    do begin
      #1;
      ok = (instr_ready && clk_en) === 1'b1;
      if (!ok) @(negedge ref_clk);
      n++;
    end while (!ok && n < 200);
    check("offer_taken", {15'h0000, ok}, 16'h0001);
    exp_q.push_back(predict(op, pc, x, b1, b2, tb, c));
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask : send

  // Free-running core clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Random stalls through the clock enable, only while a test asks for them.
  always @(negedge ref_clk) clk_en <= stall_on ? ($urandom_range(0, 3) != 0) : 1'b1;

  // Takes one note per result; a frozen pulse that stays high counts once.
  always @(posedge ref_clk) begin
    if (addr_valid === 1'b1 && !held) begin
      if (exp_q.size() == 0) begin
        check("unexpected_result", 16'h0001, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        if (e.ca) check("addr_bus", addr_bus, e.addr);
        check("next_pc", next_pc, e.npc);
        check("mode_out", 16'(mode_out), 16'(e.mode));
        check("carry_we", 16'(carry_we), 16'(e.cw));
        if (e.cw) check("carry_val", 16'(carry_val), 16'(e.cv));
        if (e.opc[7:5] == 3'h0) check("bit_num", 16'(bit_num_out), 16'(e.opc[3:1]));
        if (e.opc[7:5] == 3'h0) check("bit_sense", 16'(bit_sense_out), 16'(!e.opc[0]));
        if (e.mode == M_IMPLIED) check("uses_index", 16'(uses_index_out), 16'(e.opc[7:4] == 4'h5));
      end
    end
    held = (addr_valid === 1'b1) && (clk_en !== 1'b1);
  end

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_pc = 16'h0000;
    index_val = 8'h00;
    branch_cond = 1'b0;
    stall_on = 1'b0;
    held = 1'b0;
    fails = 0;
    checks_done = 0;
    seed_v = $urandom(32'h9c8be2e2);
    repeat (4) @(negedge ref_clk);
    check("reset_ready", 16'(instr_ready), 16'h0001);
    check("reset_rd_req", 16'(rd_req), 16'h0000);
    check("reset_valid", 16'(addr_valid), 16'h0000);
    check("reset_mode", 16'(mode_out), 16'(M_IMPLIED));
    rst_b = 1'b1;
    $display("test reset done");
    // Every opcode row, carries at the top of each sum, and wrap of the program counter.
    for (int g = 0; g < 16; g++) send({4'(g), 4'h6}, 16'h1234, 8'hff, 8'hff, 8'h81, 1'b1);
    for (int g = 0; g < 16; g++) send({4'(g), 4'h1}, 16'hfff0, 8'h01, 8'h7f, 8'h80, 1'b0);
    send(OPC_SUB_CALL, 16'h2000, 8'h00, 8'h80, 8'h00, 1'b1);
    send(8'ha6, 16'hfffe, 8'h00, 8'h11, 8'h22, 1'b0);
    $display("test rows done");
    // All bit set, clear and test opcodes.
    for (int n = 0; n < 32; n++) send(8'(n), 16'h0300 + 16'(n * 4), 8'h00, 8'h40 + 8'(n), 8'(n * 9), 1'b0);
    $display("test bit ops done");
    // Random traffic with clock-enable stalls.
    stall_on = 1'b1;
    repeat (200) send(8'($urandom), 16'h0200 + 16'($urandom_range(0, 16'hfd00)), 8'($urandom),
      8'($urandom), 8'($urandom), 1'($urandom));
    stall_on = 1'b0;
    repeat (30) @(negedge ref_clk);
    check("pending", 16'(exp_q.size()), 16'h0000);
    $display("test random done");
    give_verdict();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #(60000 * 20);
    fails++;
    give_verdict();
  end
endmodule : eag_top_bench
`default_nettype wire

// File: design/eag_calc.sv
/*
  Address arithmetic: operand location and next program counter per mode.
  Assumes operands and take are settled before the sequencer samples.
*/
`timescale 1ns/100ps
`default_nettype none
module eag_calc (
  eag_if.calc_mp bus
);
  import eag_pkg::*;

  logic [8:0] sum_b;
  logic [8:0] sum_w;
  logic [7:0] hi_w;
  logic [15:0] pc1, pc2, pc3, rel_t, btb_t;

  // The program-counter sums stay on 16 bits so the counter wraps like the core does; sum_b and sum_w are 9 bits.
  assign sum_b = {1'b0, bus.xr} + {1'b0, bus.op1};
  assign sum_w = {1'b0, bus.xr} + {1'b0, bus.op2};
  assign hi_w = bus.op1 + {7'h00, sum_w[8]};
  assign pc1 = bus.pc + PC_STEP1;
  assign pc2 = bus.pc + PC_STEP2;
  assign pc3 = bus.pc + PC_STEP3;
  assign rel_t = pc2 + {{8{bus.op1[7]}}, bus.op1};
  assign btb_t = pc3 + {{8{bus.op2[7]}}, bus.op2};

  // Per-mode selection of location and continuation.
  always_comb begin
    bus.loc = LOC_RESET;
    bus.npc = pc2;
    case (bus.mode)
      M_IMPLIED: begin
        bus.npc = pc1;
      end
      M_LITERAL: bus.loc = pc1;
      M_PAGE_ZERO: bus.loc = {PAGE_ZERO_HI, bus.op1};
      M_FULL_ADDR: begin
        bus.loc = {bus.op1, bus.op2};
        bus.npc = pc3;
      end
      M_IDX_NONE: begin
        bus.loc = {PAGE_ZERO_HI, bus.xr};
        bus.npc = pc1;
      end
      M_IDX_BYTE: bus.loc = {7'h00, sum_b};
      M_IDX_WORD: begin
        bus.loc = {hi_w, sum_w[7:0]};
        bus.npc = pc3;
      end
      M_BRANCH: begin
        bus.loc = rel_t;
        bus.npc = bus.take ? rel_t : pc2;
      end
      M_BIT_MODIFY: bus.loc = {PAGE_ZERO_HI, bus.op1};
      M_BIT_BRANCH: begin
        bus.loc = {PAGE_ZERO_HI, bus.op1};
        bus.npc = bus.take ? btb_t : pc3;
      end
      default: bus.loc = LOC_RESET;
    endcase
  end
endmodule : eag_calc
`default_nettype wire

// File: design/eag_dec.sv
/*
  Opcode decoder: addressing mode, instruction length and bit fields.
  Assumes the opcode on the carrier is stable while it is used.
*/
`timescale 1ns/100ps
`default_nettype none
module eag_dec (
  eag_if.dec_mp bus
);
  import eag_pkg::*;

  // Mode by opcode-map column; the subroutine call is the one relative oddity.
  function automatic eag_mode_t mode_of(input logic [7:0] op);
    if (op == OPC_SUB_CALL) begin
      return M_BRANCH;
    end
    case (op[7:4])
      GRP_BIT_BRANCH: return M_BIT_BRANCH;
      GRP_BIT_MODIFY: return M_BIT_MODIFY;
      GRP_BRANCH: return M_BRANCH;
      GRP_PZ_RMW, GRP_PZ: return M_PAGE_ZERO;
      GRP_IDXB_RMW, GRP_IDXB: return M_IDX_BYTE;
      GRP_IDXN_RMW, GRP_IDXN: return M_IDX_NONE;
      GRP_LITERAL: return M_LITERAL;
      GRP_FULL: return M_FULL_ADDR;
      GRP_IDXW: return M_IDX_WORD;
      default: return M_IMPLIED;
    endcase
  endfunction : mode_of

  // Byte count follows from the mode alone.
  function automatic logic [1:0] len_of(input eag_mode_t m);
    case (m)
      M_IMPLIED, M_IDX_NONE: return LEN_ONE;
      M_FULL_ADDR, M_IDX_WORD, M_BIT_BRANCH: return LEN_THREE;
      default: return LEN_TWO;
    endcase
  endfunction : len_of

  // Bit number and set/clear sense share the low nibble in both bit groups.
  assign bus.mode = mode_of(bus.opcode);
  assign bus.nbytes = len_of(mode_of(bus.opcode));
  assign bus.bit_num = bus.opcode[BIT_FIELD_LSB +: 3];
  assign bus.bit_sense = ~bus.opcode[SENSE_POS];
  assign bus.uses_index = (bus.opcode[7:4] == GRP_IMPL_IDX);
endmodule : eag_dec
`default_nettype wire

// File: design/eag_if.sv
/*
  Carrier between the decoder, the arithmetic unit and the sequencer.
  Assumes the sequencer drives opcode and operand fields.
*/
`timescale 1ns/100ps
`default_nettype none
interface eag_if;
  import eag_pkg::*;
  logic [7:0] opcode;
  logic [7:0] xr;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [15:0] pc;
  logic take;
  eag_mode_t mode;
  logic [1:0] nbytes;
  logic [2:0] bit_num;
  logic bit_sense;
  logic uses_index;
  logic [15:0] loc;
  logic [15:0] npc;

  modport dec_mp (input opcode, output mode, nbytes, bit_num, bit_sense, uses_index);
  modport calc_mp (input mode, pc, xr, op1, op2, take, output loc, npc);
  modport seq_mp (output opcode, xr, op1, op2, pc, take,
                  input mode, nbytes, bit_num, bit_sense, uses_index, loc, npc);
endinterface : eag_if
`default_nettype wire

// File: design/eag_pkg.sv
/*
  Shared constants, types and state names for the operand effective-address
  generator. Assumes one core clock and an 8-bit opcode map arranged by high nibble.
*/
// Summary of operation
// - Implied mode: opcode only, no operand fetch.
// - Literal: location is pc plus one, pc advances two.
// - Page zero: high byte zero, low from operand.
// - Full address: high first operand, low second; pc+3.
// - Indexed plain: location is index register; pc+1.
// - Byte offset: index plus operand, carry is high byte.
// - Word offset: index plus second, carry into first.
// - Branch: pc+2 plus signed offset when condition holds.
// - Bit modify: page-zero address, bit field from opcode.
// - Bit branch: three bytes, branch when bit matches sense.
// - Low nibble encodes bit number and set/clear sense.
// - Tested bit always copied into carry flag.
package eag_pkg;

  typedef enum logic [3:0] {
    M_IMPLIED, M_LITERAL, M_PAGE_ZERO, M_FULL_ADDR, M_IDX_NONE,
    M_IDX_BYTE, M_IDX_WORD, M_BRANCH, M_BIT_MODIFY, M_BIT_BRANCH
  } eag_mode_t;

  typedef enum logic [2:0] {S_IDLE, S_OP1, S_OP2, S_DATA, S_EXEC} eag_state_t;

  // High-nibble groups of the opcode map.
  localparam logic [3:0] GRP_BIT_BRANCH = 4'h0;
  localparam logic [3:0] GRP_BIT_MODIFY = 4'h1;
  localparam logic [3:0] GRP_BRANCH = 4'h2;
  localparam logic [3:0] GRP_PZ_RMW = 4'h3;
  localparam logic [3:0] GRP_IMPL_ACC = 4'h4;
  localparam logic [3:0] GRP_IMPL_IDX = 4'h5;
  localparam logic [3:0] GRP_IDXB_RMW = 4'h6;
  localparam logic [3:0] GRP_IDXN_RMW = 4'h7;
  localparam logic [3:0] GRP_CTRL_A = 4'h8;
  localparam logic [3:0] GRP_CTRL_B = 4'h9;
  localparam logic [3:0] GRP_LITERAL = 4'ha;
  localparam logic [3:0] GRP_PZ = 4'hb;
  localparam logic [3:0] GRP_FULL = 4'hc;
  localparam logic [3:0] GRP_IDXW = 4'hd;
  localparam logic [3:0] GRP_IDXB = 4'he;
  localparam logic [3:0] GRP_IDXN = 4'hf;
  localparam logic [7:0] OPC_SUB_CALL = 8'had;

  // Opcode fields: bit number in bits 3..1, sense in bit 0 (0 means set).
  localparam int BIT_FIELD_LSB = 1;
  localparam int SENSE_POS = 0;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [15:0] PC_STEP1 = 16'h0001;
  localparam logic [15:0] PC_STEP2 = 16'h0002;
  localparam logic [15:0] PC_STEP3 = 16'h0003;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] LOC_RESET = 16'h0000;

endpackage : eag_pkg

// File: design/eag_top.sv
/*
  Effective-address sequencer: accepts an opcode, fetches its operand bytes,
  reads the tested byte for bit branches and presents the operand location
  and next program counter. Assumes the memory answers on the same clock and
  holds rd_data valid with rd_valid until rd_req takes it.
*/
`timescale 1ns/100ps
`default_nettype none
module eag_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [7:0] instr_opcode,
  input wire logic [15:0] instr_pc,
  input wire logic [7:0] index_val,
  input wire logic branch_cond,
  output logic instr_ready,
  output logic rd_req,
  output logic [15:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic [15:0] addr_bus,
  output logic addr_valid,
  output logic [15:0] next_pc,
  output eag_pkg::eag_mode_t mode_out,
  output logic [2:0] bit_num_out,
  output logic bit_sense_out,
  output logic uses_index_out,
  output logic carry_we,
  output logic carry_val
);
  import eag_pkg::*;

  eag_if bus ();
  eag_state_t state_q, state_d;
  logic [7:0] opcode_q, x_q, op1_q, op2_q;
  logic [15:0] pc_q;
  logic tbit_q, take_q;
  logic [1:0] fetch_cnt_q;
  logic accept, got;
  logic [15:0] loc_q, npc_q;
  logic valid_q, cwe_q, cval_q, sense_q, uidx_q;
  logic [2:0] bnum_q;
  eag_mode_t mode_q;

  eag_dec u_dec (.bus(bus.dec_mp));
  eag_calc u_calc (.bus(bus.calc_mp));

  // Decode the incoming opcode while idle so the first step is known at once.
  assign bus.opcode = (state_q == S_IDLE) ? instr_opcode : opcode_q;
  assign bus.xr = x_q;
  assign bus.op1 = op1_q;
  assign bus.op2 = op2_q;
  assign bus.pc = pc_q;
  assign bus.take = (bus.mode == M_BRANCH) ? branch_cond : (tbit_q == bus.bit_sense);

  // Handshakes: a fetch is outstanding in each operand or data state.
  assign instr_ready = (state_q == S_IDLE);
  assign accept = instr_valid && instr_ready && clk_en;
  assign got = rd_valid && rd_req;
  assign rd_req = clk_en && (state_q == S_OP1 || state_q == S_OP2 || state_q == S_DATA);
  assign rd_addr = (state_q == S_OP1) ? pc_q + PC_STEP1 :
                   (state_q == S_OP2) ? pc_q + PC_STEP2 :
                   (state_q == S_DATA) ? {PAGE_ZERO_HI, op1_q} : LOC_RESET;

  // Next state; one-byte forms skip every fetch.
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (accept) state_d = (bus.nbytes == LEN_ONE) ? S_EXEC : S_OP1;
      S_OP1: if (got) state_d = (bus.nbytes == LEN_THREE) ? S_OP2 : S_EXEC;
      S_OP2: if (got) state_d = (bus.mode == M_BIT_BRANCH) ? S_DATA : S_EXEC;
      S_DATA: if (got) state_d = S_EXEC;
      S_EXEC: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // State register; everything here holds while clk_en is low.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Instruction context; the index value is copied, never written back.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opcode_q <= 8'h00;
      pc_q <= 16'h0000;
      x_q <= 8'h00;
    end else if (accept) begin
      opcode_q <= instr_opcode;
      pc_q <= instr_pc;
      x_q <= index_val;
    end
  end

  // Operand bytes and the tested bit, captured as each read returns.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op1_q <= 8'h00;
      op2_q <= 8'h00;
      tbit_q <= 1'b0;
    end else if (clk_en && got) begin
      if (state_q == S_OP1) op1_q <= rd_data;
      if (state_q == S_OP2) op2_q <= rd_data;
      if (state_q == S_DATA) tbit_q <= rd_data[bus.bit_num];
    end
  end

  // Count of reads per instruction, kept for the checks below.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_cnt_q <= 2'h0;
    end else if (clk_en) begin
      if (accept) fetch_cnt_q <= 2'h0;
      else if (got) fetch_cnt_q <= fetch_cnt_q + 2'h1;
    end
  end

  // Results are registered in the execute cycle that follows the last read.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loc_q <= LOC_RESET;
      npc_q <= 16'h0000;
      valid_q <= 1'b0;
      cwe_q <= 1'b0;
      cval_q <= 1'b0;
      take_q <= 1'b0;
      mode_q <= M_IMPLIED;
      bnum_q <= 3'h0;
      sense_q <= 1'b0;
      uidx_q <= 1'b0;
    end else if (clk_en) begin
      valid_q <= (state_q == S_EXEC);
      cwe_q <= (state_q == S_EXEC) && (bus.mode == M_BIT_BRANCH);
      if (state_q == S_EXEC) begin
        loc_q <= bus.loc;
        npc_q <= bus.npc;
        cval_q <= tbit_q;
        take_q <= bus.take;
        mode_q <= bus.mode;
        bnum_q <= bus.bit_num;
        sense_q <= bus.bit_sense;
        uidx_q <= bus.uses_index;
      end
    end
  end

  assign addr_bus = loc_q;
  assign addr_valid = valid_q;
  assign next_pc = npc_q;
  assign mode_out = mode_q;
  assign bit_num_out = bnum_q;
  assign bit_sense_out = sense_q;
  assign uses_index_out = uidx_q;
  assign carry_we = cwe_q;
  assign carry_val = cval_q;

  // Checks on the registered results against the captured context.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic [8:0] chk_sum_b;
  logic [8:0] chk_sum_w;
  assign chk_sum_b = {1'b0, x_q} + {1'b0, op1_q};
  assign chk_sum_w = {1'b0, x_q} + {1'b0, op2_q};

  implied_nofetch_a: assert property ((state_q == S_EXEC) && (bus.mode == M_IMPLIED) && clk_en |->
    (fetch_cnt_q == 2'h0) ##1 (addr_valid && next_pc == pc_q + PC_STEP1)) else $error("implied fetched");
  literal_loc_a: assert property (addr_valid && mode_out == M_LITERAL |->
    addr_bus == pc_q + PC_STEP1 && next_pc == pc_q + PC_STEP2) else $error("literal address wrong");
  page_zero_a: assert property (addr_valid && mode_out == M_PAGE_ZERO |->
    addr_bus == {8'h00, op1_q} && next_pc == pc_q + PC_STEP2) else $error("page zero address wrong");
  full_addr_a: assert property (addr_valid && mode_out == M_FULL_ADDR |->
    addr_bus == {op1_q, op2_q} && next_pc == pc_q + PC_STEP3) else $error("full address wrong");
  idx_none_a: assert property (addr_valid && mode_out == M_IDX_NONE |->
    addr_bus == {8'h00, x_q} && next_pc == pc_q + PC_STEP1) else $error("plain indexed wrong");
  idx_byte_a: assert property (addr_valid && mode_out == M_IDX_BYTE |->
    addr_bus == {7'h00, chk_sum_b} && x_q == $past(x_q)) else $error("byte offset wrong");
  idx_word_a: assert property (addr_valid && mode_out == M_IDX_WORD |->
    addr_bus == {op1_q + {7'h00, chk_sum_w[8]}, chk_sum_w[7:0]}) else $error("word offset wrong");
  branch_pc_a: assert property (addr_valid && mode_out == M_BRANCH |->
    next_pc == (take_q ? pc_q + PC_STEP2 + {{8{op1_q[7]}}, op1_q} : pc_q + PC_STEP2)) else $error("branch wrong");
  bit_modify_a: assert property (addr_valid && mode_out == M_BIT_MODIFY |->
    addr_bus == {8'h00, op1_q} && bit_num_out == opcode_q[3:1] && fetch_cnt_q == 2'h1) else $error("bit modify wrong");
  bit_branch_a: assert property (addr_valid && mode_out == M_BIT_BRANCH |->
    fetch_cnt_q == 2'h3 && next_pc == ((carry_val == bit_sense_out) ?
    pc_q + PC_STEP3 + {{8{op2_q[7]}}, op2_q} : pc_q + PC_STEP3)) else $error("bit branch wrong");
  opcode_map_a: assert property ((state_q == S_IDLE) && instr_opcode[7:5] == 3'h0 |->
    (bus.mode == (instr_opcode[4] ? M_BIT_MODIFY : M_BIT_BRANCH)) && bus.bit_sense == !instr_opcode[0])
    else $error("bit opcode decode wrong");
  carry_copy_a: assert property (addr_valid && mode_out == M_BIT_BRANCH |->
    carry_we && carry_val == tbit_q) else $error("carry not copied");
  // A stall in the result cycle freezes the pulse, so it may only stand longer when clk_en was low.
  show_after_a: assert property ((state_q == S_EXEC) && clk_en |=> addr_valid ##1 (!addr_valid || !$past(clk_en)))
    else $error("location not presented");

  lit_cov_c: cover property (addr_valid && mode_out == M_LITERAL);
  br_taken_c: cover property (addr_valid && mode_out == M_BRANCH && take_q);
  btb_cov_c: cover property (addr_valid && mode_out == M_BIT_BRANCH && !take_q);
  word_carry_c: cover property (addr_valid && mode_out == M_IDX_WORD && chk_sum_w[8]);
endmodule : eag_top
`default_nettype wire
